// ==== i2csr_slave.sv ====
`timescale 1ns/10ps
module i2csr_slave #(
    parameter int FIFO_DEPTH = i2csr_pkg::FIFO_DEPTH
) (
    input wire logic clk_i, // System clock, 50 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic scl_i, // Bus clock pin level
    input wire logic sda_i, // Bus data pin level
    output logic sda_o, // Bus data drive value, always low
    output logic sda_oe_o, // High while pulling SDA low
    input wire logic addr_select_upper_pin_i, // Upper address-select pin
    input wire logic addr_select_lower_pin_i, // Lower address-select pin
    output logic wr_valid_o, // Written register byte waiting
    input wire logic wr_ready_i, // Register side takes the byte
    output i2csr_pkg::i2csr_wr_t wr_item_o, // Register index and data
    output logic [3:0] rd_index_o, // Register index for the next read
    input wire logic [7:0] rd_data_i, // Contents of register rd_index_o
    output logic rd_strobe_o, // Pulse: rd_data_i was taken
    output logic bus_busy_o // Bus held between START and STOP
);
    logic [3:0] sync_m_r;
    logic [3:0] sync_s_r;
    logic [3:0] prev_r;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
    logic rise;
    logic fall;
    logic start_ev;
    logic stop_ev;
    logic [1:0] v10_r;
    logic [1:0] v01_r;
    logic [1:0] upper_code;
    logic [1:0] lower_code;
    logic [6:0] own_addr;
    logic addr_match;
    i2csr_pkg::i2csr_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic [3:0] ptr_r;
    logic busy_r;
    logic oe_r;
    logic strobe_r;
    logic ack_fall;
    logic end_fall;
    logic fifo_valid;
    logic fifo_ready;
    logic tx_load;
    i2csr_pkg::i2csr_wr_t wr_in;

    function automatic logic [1:0] pin_code(input logic hi_lo, input logic lo_hi);
        logic [1:0] code;
        code = i2csr_pkg::PIN_SDA;
        unique case ({hi_lo, lo_hi})
            2'b11: code = i2csr_pkg::PIN_VDD;
            2'b00: code = i2csr_pkg::PIN_VSS;
            2'b10: code = i2csr_pkg::PIN_SCL;
            2'b01: code = i2csr_pkg::PIN_SDA;
        endcase
        return code;
    endfunction

    // Two-stage synchronisers for all pins, then one stage for edges
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_m_r <= i2csr_pkg::SYNC_RST;
            sync_s_r <= i2csr_pkg::SYNC_RST;
            prev_r <= i2csr_pkg::SYNC_RST;
        end
        else
        begin
            sync_m_r <= {scl_i, sda_i, addr_select_upper_pin_i, addr_select_lower_pin_i};
            sync_s_r <= sync_m_r;
            prev_r <= sync_s_r;
        end
    end

    assign scl_s = sync_s_r[3];
    assign sda_s = sync_s_r[2];
    assign scl_p = prev_r[3];
    assign sda_p = prev_r[2];
    assign rise = scl_s && !scl_p;
    assign fall = !scl_s && scl_p;
    assign start_ev = scl_s && scl_p && sda_p && !sda_s;
    assign stop_ev = scl_s && scl_p && !sda_p && sda_s;

    // Pin level seen with SCL high/SDA low and with SCL low/SDA high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            v10_r <= i2csr_pkg::PINV_RST;
            v01_r <= i2csr_pkg::PINV_RST;
        end
        else if (scl_s && !sda_s)
        begin
            v10_r <= sync_s_r[1:0];
        end
        else if (!scl_s && sda_s)
        begin
            v01_r <= sync_s_r[1:0];
        end
    end

    assign upper_code = pin_code(v10_r[1], v01_r[1]);
    assign lower_code = pin_code(v10_r[0], v01_r[0]);
    assign own_addr = i2csr_pkg::BASE_ADDR + {3'h0, upper_code, lower_code};
    assign addr_match = (rx_r[7:1] == own_addr);

    assign ack_fall = fall && (cnt_r == i2csr_pkg::ACK_FALL);
    assign end_fall = fall && (cnt_r == i2csr_pkg::END_FALL);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_r <= 1'b0;
        end
        else if (start_ev)
        begin
            busy_r <= 1'b1;
        end
        else if (stop_ev)
        begin
            busy_r <= 1'b0;
        end
    end

    // Rising edges seen in the current byte, ninth is the acknowledge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= i2csr_pkg::CNT_RST;
        end
        else if (start_ev || stop_ev)
        begin
            cnt_r <= 4'h0;
        end
        else if (end_fall)
        begin
            cnt_r <= 4'h0;
        end
        else if (rise && busy_r)
        begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_r <= i2csr_pkg::BYTE_RST;
        end
        else if (rise && busy_r && (cnt_r < i2csr_pkg::ACK_FALL))
        begin
            rx_r <= {rx_r[6:0], sda_s};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rw_r <= 1'b0;
        end
        else if (ack_fall && (state_r == i2csr_pkg::ST_ADDR))
        begin
            rw_r <= rx_r[0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= i2csr_pkg::ST_IDLE;
        end
        else if (start_ev)
        begin
            state_r <= i2csr_pkg::ST_ADDR;
        end
        else if (stop_ev)
        begin
            state_r <= i2csr_pkg::ST_IDLE;
        end
        else if (rise && (cnt_r == i2csr_pkg::ACK_FALL) && sda_s
                 && (state_r == i2csr_pkg::ST_RDATA))
        begin
            state_r <= i2csr_pkg::ST_IGNORE;
        end
        else if (ack_fall)
        begin
            unique case (state_r)
                i2csr_pkg::ST_ADDR:
                begin
                    if (!addr_match)
                    begin
                        state_r <= i2csr_pkg::ST_IGNORE;
                    end
                end
                i2csr_pkg::ST_WDATA:
                begin
                    if (!fifo_ready)
                    begin
                        state_r <= i2csr_pkg::ST_IGNORE;
                    end
                end
                i2csr_pkg::ST_IDLE, i2csr_pkg::ST_SUB, i2csr_pkg::ST_RDATA,
                i2csr_pkg::ST_IGNORE:
                begin
                    state_r <= state_r;
                end
            endcase
        end
        else if (end_fall)
        begin
            unique case (state_r)
                i2csr_pkg::ST_ADDR:
                begin
                    state_r <= rw_r ? i2csr_pkg::ST_RDATA : i2csr_pkg::ST_SUB;
                end
                i2csr_pkg::ST_SUB:
                begin
                    state_r <= i2csr_pkg::ST_WDATA;
                end
                i2csr_pkg::ST_IDLE, i2csr_pkg::ST_WDATA, i2csr_pkg::ST_RDATA,
                i2csr_pkg::ST_IGNORE:
                begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Next byte to send is fetched at the end of each acknowledged slot of a read
    assign tx_load = end_fall && (((state_r == i2csr_pkg::ST_ADDR) && rw_r)
                     || (state_r == i2csr_pkg::ST_RDATA));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_r <= i2csr_pkg::BYTE_RST;
        end
        else if (tx_load)
        begin
            tx_r <= rd_data_i;
        end
        else if (fall && (state_r == i2csr_pkg::ST_RDATA) && (cnt_r != 4'h0)
                 && (cnt_r < i2csr_pkg::ACK_FALL))
        begin
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // Open-drain drive: only acknowledges and zero data bits pull low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            oe_r <= 1'b0;
        end
        else if (start_ev || stop_ev)
        begin
            oe_r <= 1'b0;
        end
        else if (tx_load)
        begin
            oe_r <= !rd_data_i[7];
        end
        else if (end_fall)
        begin
            oe_r <= 1'b0;
        end
        else if (ack_fall)
        begin
            unique case (state_r)
                i2csr_pkg::ST_ADDR: oe_r <= addr_match;
                i2csr_pkg::ST_SUB: oe_r <= 1'b1;
                i2csr_pkg::ST_WDATA: oe_r <= fifo_ready;
                i2csr_pkg::ST_RDATA: oe_r <= 1'b0;
                i2csr_pkg::ST_IDLE, i2csr_pkg::ST_IGNORE: oe_r <= 1'b0;
            endcase
        end
        else if (fall && (state_r == i2csr_pkg::ST_RDATA) && (cnt_r != 4'h0))
        begin
            oe_r <= !tx_r[6];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr_r <= i2csr_pkg::PTR_RST;
        end
        else if (ack_fall && (state_r == i2csr_pkg::ST_SUB))
        begin
            ptr_r <= rx_r[i2csr_pkg::SUB_HI:i2csr_pkg::SUB_LO];
        end
        else if (tx_load || (fifo_valid && fifo_ready))
        begin
            ptr_r <= ptr_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            strobe_r <= 1'b0;
        end
        else
        begin
            strobe_r <= tx_load;
        end
    end

    // A full buffer refuses the byte with a not-acknowledge
    assign fifo_valid = ack_fall && (state_r == i2csr_pkg::ST_WDATA);
    assign wr_in.index = ptr_r;
    assign wr_in.data = rx_r;

    i2csr_fifo #(
        .WIDTH($bits(i2csr_pkg::i2csr_wr_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(wr_in),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(wr_item_o)
    );

    assign sda_o = 1'b0;
    assign sda_oe_o = oe_r;
    assign rd_index_o = ptr_r;
    assign rd_strobe_o = strobe_r;
    assign bus_busy_o = busy_r;

    a_stable_scl_high: assert property (@(posedge clk_i) disable iff (rst_i)
        (scl_s && scl_p && !start_ev && !stop_ev) |-> $stable(sda_oe_o))
        else $error("SDA drive changed while SCL high");

    a_start_new_byte: assert property (@(posedge clk_i) disable iff (rst_i)
        start_ev |=> (state_r == i2csr_pkg::ST_ADDR) && (cnt_r == 4'h0) && !sda_oe_o)
        else $error("START did not restart address phase");

    a_stop_goes_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_ev |=> (state_r == i2csr_pkg::ST_IDLE) && !bus_busy_o && !sda_oe_o)
        else $error("STOP did not return to idle");

    a_busy_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_ev ##1 (!stop_ev && !start_ev) [*3]) |-> bus_busy_o)
        else $error("Bus not busy after START");

    a_addr_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_fall && (state_r == i2csr_pkg::ST_ADDR) && !start_ev && !stop_ev)
        |=> (sda_oe_o == $past(addr_match)))
        else $error("Address acknowledge does not follow match");

    a_nomatch_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == i2csr_pkg::ST_IGNORE) && $past(state_r == i2csr_pkg::ST_IGNORE)
        |-> !sda_oe_o)
        else $error("SDA driven while ignoring bus");

    a_tx_release_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == i2csr_pkg::ST_RDATA) && (cnt_r == i2csr_pkg::ACK_FALL) && !scl_s
        && !fall |-> !sda_oe_o)
        else $error("Transmitter holds SDA in acknowledge slot");

    a_nack_ends_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (rise && sda_s && (cnt_r == i2csr_pkg::ACK_FALL) && !start_ev && !stop_ev
        && (state_r == i2csr_pkg::ST_RDATA)) |=> ##1 (state_r == i2csr_pkg::ST_IGNORE))
        else $error("Not-acknowledge did not end transmission");

    a_sub_index: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_fall && (state_r == i2csr_pkg::ST_SUB) && !start_ev && !stop_ev)
        |=> (ptr_r == $past(rx_r[i2csr_pkg::SUB_HI:i2csr_pkg::SUB_LO])) && sda_oe_o)
        else $error("Sub-address not taken from bits 6 to 3");

    a_write_pushed: assert property (@(posedge clk_i) disable iff (rst_i)
        (fifo_valid && fifo_ready && !start_ev && !stop_ev)
        |=> wr_valid_o && sda_oe_o && (ptr_r == $past(ptr_r) + 4'h1))
        else $error("Accepted write byte not stored and acknowledged");

endmodule

// ==== i2csr_pkg.sv ====
package i2csr_pkg;

    // Seven-bit form of the lowest selectable slave address byte
    localparam logic [6:0] BASE_ADDR = 7'h48;

    // Rising-edge count at the falling edge that opens the acknowledge slot
    localparam logic [3:0] ACK_FALL = 4'h8;
    // Rising-edge count at the falling edge that closes the acknowledge slot
    localparam logic [3:0] END_FALL = 4'h9;

    // Register select field inside the sub-address byte
    localparam int SUB_HI = 6;
    localparam int SUB_LO = 3;

    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] SYNC_RST = 4'hf;
    localparam logic [1:0] PINV_RST = 2'h3;

    // Four-state address-select pin codes
    localparam logic [1:0] PIN_VDD = 2'h0;
    localparam logic [1:0] PIN_VSS = 2'h1;
    localparam logic [1:0] PIN_SCL = 2'h2;
    localparam logic [1:0] PIN_SDA = 2'h3;

    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [3:0] index;
        logic [7:0] data;
    } i2csr_wr_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_SUB = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_IGNORE = 6'h20
    } i2csr_state_t;

endpackage

// ==== i2csr_fifo.sv ====
`timescale 1ns/10ps
module i2csr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic in_valid_i, // Filling side offers a word
    output logic in_ready_o, // Room for one more word
    input wire logic [WIDTH-1:0] in_data_i, // Word to store
    output logic out_valid_o, // A word is waiting
    input wire logic out_ready_i, // Draining side takes the word
    output logic [WIDTH-1:0] out_data_o // Oldest stored word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != FULL_CNT);
    assign out_valid_o = (cnt_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rp_r];

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_r <= (wp_r == LAST_PTR) ? '0 : wp_r + 1'b1;
            end
            if (pop)
            begin
                rp_r <= (rp_r == LAST_PTR) ? '0 : rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
        end
        else if (push && !pop)
        begin
            cnt_r <= cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

endmodule

// ==== i2csr_master_model.sv ====
`timescale 1ns/10ps
module i2csr_master_model (
    input wire logic clk_i, // System clock
    input wire logic sda_i, // Resolved data line
    output logic scl_o, // Bus clock, high while idle
    output logic sda_oe_o // High while pulling SDA low
);
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Works from idle or two cycles into a low phase, so it also serves as repeated START
    task automatic start_cond();
        sda_oe_o <= 1'b0;
        wait_clk(3);
        scl_o <= 1'b1;
        wait_clk(4);
        sda_oe_o <= 1'b1;
        wait_clk(4);
        scl_o <= 1'b0;
        wait_clk(2);
    endtask

    task automatic stop_cond();
        sda_oe_o <= 1'b1;
        wait_clk(3);
        scl_o <= 1'b1;
        wait_clk(4);
        sda_oe_o <= 1'b0;
        wait_clk(8);
    endtask

    // Five cycles low, three high; SDA moves only while SCL is low
    task automatic bit_xfer(input logic b, output logic r);
        sda_oe_o <= ~b;
        wait_clk(3);
        scl_o <= 1'b1;
        wait_clk(2);
        r = sda_i;
        wait_clk(1);
        scl_o <= 1'b0;
        wait_clk(2);
    endtask

    // Ninth slot: nine high releases the line, low acknowledges a read byte
    task automatic byte_xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
        output logic slot);
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(tx[i], rx[i]);
        end
        bit_xfer(nine, slot);
    endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic scl;
    logic m_oe;
    logic sda;
    logic s_drv;
    logic s_oe;
    logic pin_hi;
    logic pin_lo;
    logic [3:0] code = 4'h0;
    logic wr_valid;
    logic wr_ready_i = 1'b0;
    i2csr_pkg::i2csr_wr_t wr_item;
    logic [3:0] rd_index;
    logic [7:0] rd_data;
    logic rd_strobe;
    logic bus_busy;
    logic hold = 1'b0;
    logic [31:0] rnd;
    logic [7:0] regs [16];
    logic [7:0] ab;
    int seed = 32'he098;
    int errors = 0;
    int compares = 0;
    int strobes = 0;
    i2csr_pkg::i2csr_wr_t expq[$];
    i2csr_pkg::i2csr_wr_t got[$];

    always #10 clk_i = ~clk_i;

    // Pull-up line: low while either party pulls
    assign sda = ~(m_oe | (s_oe & ~s_drv));
    assign pin_hi = pin_lvl(code[3:2], scl, sda);
    assign pin_lo = pin_lvl(code[1:0], scl, sda);
    assign rd_data = regs[rd_index];

    i2csr_master_model u_i2csr_master_model (
        .clk_i(clk_i),
        .sda_i(sda),
        .scl_o(scl),
        .sda_oe_o(m_oe)
    );

    i2csr_slave #(.FIFO_DEPTH(i2csr_pkg::FIFO_DEPTH)) u_i2csr_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(s_drv),
        .sda_oe_o(s_oe),
        .addr_select_upper_pin_i(pin_hi),
        .addr_select_lower_pin_i(pin_lo),
        .wr_valid_o(wr_valid),
        .wr_ready_i(wr_ready_i),
        .wr_item_o(wr_item),
        .rd_index_o(rd_index),
        .rd_data_i(rd_data),
        .rd_strobe_o(rd_strobe),
        .bus_busy_o(bus_busy)
    );

    // Sink stalls at random and logs every word it takes
    always @(posedge clk_i)
    begin
        rnd = $random(seed);
        wr_ready_i <= ~hold & rnd[0];
        if (wr_valid === 1'b1 && wr_ready_i === 1'b1)
        begin
            got.push_back(wr_item);
        end
        if (rd_strobe === 1'b1)
        begin
            strobes++;
        end
    end

    function automatic logic pin_lvl(input logic [1:0] k, input logic s, input logic d);
        case (k)
            i2csr_pkg::PIN_VDD: return 1'b1;
            i2csr_pkg::PIN_VSS: return 1'b0;
            i2csr_pkg::PIN_SCL: return s;
            default: return d;
        endcase
    endfunction

    function automatic logic [7:0] abyte(input logic [3:0] c);
        return 8'h90 + {3'h0, c, 1'b0};
    endfunction

    function automatic logic [7:0] rsub();
        logic [31:0] r;
        r = $random(seed);
        return {r[7:3], 2'b00, r[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic stop_busy();
        u_i2csr_master_model.stop_cond();
        check("busy after stop", 0, bus_busy);
    endtask

    task automatic drain_check();
        int k = 0;
        while (got.size() < expq.size() && k < 600)
        begin
            @(posedge clk_i);
            k++;
        end
        repeat (4) @(posedge clk_i);
        check("items taken", expq.size(), got.size());
        if (got.size() != expq.size())
        begin
            results();
        end
        while (expq.size() > 0)
        begin
            check("write item", expq.pop_front(), got.pop_front());
        end
    endtask

    task automatic wr_txn(input logic [7:0] a, input logic [7:0] sub, input int n,
        input int room, input logic m);
        logic [7:0] rx;
        logic nk;
        logic [7:0] d;
        logic [3:0] idx;
        idx = sub[6:3];
        u_i2csr_master_model.start_cond();
        check("busy after start", 1, bus_busy);
        u_i2csr_master_model.byte_xfer({a[7:1], 1'b0}, 1'b1, rx, nk);
        check("address ack", !m, nk);
        u_i2csr_master_model.byte_xfer(sub, 1'b1, rx, nk);
        check("sub ack", !m, nk);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            u_i2csr_master_model.byte_xfer(d, 1'b1, rx, nk);
            check("data ack", !(m && i < room), nk);
            if (m && i < room)
            begin
                expq.push_back({idx, d});
                idx++;
            end
        end
        stop_busy();
    endtask

    task automatic rd_txn(input logic [7:0] a, input logic [7:0] sub, input int n);
        logic [7:0] rx;
        logic nk;
        logic [3:0] idx;
        int s0;
        idx = sub[6:3];
        u_i2csr_master_model.start_cond();
        u_i2csr_master_model.byte_xfer({a[7:1], 1'b0}, 1'b1, rx, nk);
        check("address ack", 0, nk);
        u_i2csr_master_model.byte_xfer(sub, 1'b1, rx, nk);
        check("sub ack", 0, nk);
        u_i2csr_master_model.start_cond();
        u_i2csr_master_model.byte_xfer({a[7:1], 1'b1}, 1'b1, rx, nk);
        check("read address ack", 0, nk);
        s0 = strobes;
        for (int i = 0; i < n; i++)
        begin
            u_i2csr_master_model.byte_xfer(8'hff, i == n - 1, rx, nk);
            check("read data", regs[idx], rx);
            idx++;
        end
        check("last slot released", 1, nk);
        stop_busy();
        check("read strobes", n, strobes - s0);
    endtask

    initial
    begin
        for (int k = 0; k < 16; k++)
        begin
            regs[k] = 8'($random(seed));
        end
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("idle busy", 0, bus_busy);
        for (int c = 0; c < 16; c++)
        begin
            code <= c[3:0];
            ab = abyte(c[3:0]);
            repeat (2) @(posedge clk_i);
            wr_txn(ab, rsub(), 2, 16, 1'b1);
            wr_txn(ab ^ 8'h02, rsub(), 1, 0, 1'b0);
            drain_check();
        end
        for (int t = 0; t < 6; t++)
        begin
            wr_txn(ab, rsub(), 1 + $unsigned($random(seed)) % 5, 16, 1'b1);
            drain_check();
        end
        wr_txn(ab, 8'h78, 3, 16, 1'b1);
        drain_check();
        rd_txn(ab, 8'h78, 3);
        for (int t = 0; t < 4; t++)
        begin
            rd_txn(ab, rsub(), 1 + $unsigned($random(seed)) % 4);
        end
        hold <= 1'b1;
        wr_txn(ab, rsub(), i2csr_pkg::FIFO_DEPTH + 2, i2csr_pkg::FIFO_DEPTH, 1'b1);
        hold <= 1'b0;
        drain_check();
        results();
    end
endmodule
